// ### core/wdat_pkg.sv
// How it works
// RULE_01 - enable bit resets to one, counting starts
// RULE_02 - software disables: irq off, clear, enable0, disable
// RULE_03 - command codes: clear, disable, trap commit only
// RULE_04 - disable code acts only with enable bit zero
// RULE_05 - disabled watchdog holds binary counter cleared
// RULE_06 - clear resets binary counter, never the divider
// RULE_07 - overflow with select zero raises watchdog interrupt
// RULE_08 - watchdog interrupt ignores the global enable flag
// RULE_09 - new watchdog interrupt preempts, old one pends
// RULE_10 - software sets stack before interrupt mode selection
// RULE_11 - output select, once zero, stays zero until reset
// RULE_12 - overflow with select one requests system reset
// RULE_13 - trap or watchdog reset lasts 24 fc periods
// RULE_14 - low-speed reset restarts fast oscillator, timed by it
// RULE_15 - watchdog holds its count in stop, idle, sleep
// RULE_16 - ram trap bit applies only after commit code
// RULE_17 - fetch from register areas always traps
// RULE_18 - trap with action zero raises trap interrupt
// RULE_19 - trap with action one requests system reset
// RULE_20 - trap interrupt ignores the global enable flag
// RULE_21 - new trap interrupt preempts, old one pends
// RULE_22 - detect-time code picks divider tap, 00 longest
package wdat_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0]  CTRL_IDX       = 8'h34;
  localparam logic [7:0]  CMD_IDX        = 8'h35;
  localparam logic [7:0]  STAT_IDX       = 8'h38;
  localparam logic [9:0]  CTRL_ADDR      = {CTRL_IDX, 2'h0};
  localparam logic [9:0]  CMD_ADDR       = {CMD_IDX, 2'h0};
  localparam logic [9:0]  STAT_ADDR      = {STAT_IDX, 2'h0};

  // control register fields
  localparam int          CTL_RAMTRAP    = 5;
  localparam int          CTL_TRAPACT    = 4;
  localparam int          CTL_ENABLE     = 3;
  localparam int          CTL_DT_HI      = 2;
  localparam int          CTL_DT_LO      = 1;
  localparam int          CTL_OUTSEL     = 0;
  localparam logic [7:0]  CTRL_RESET     = 8'h39;

  // command codes
  localparam logic [7:0]  CMD_CLEAR      = 8'h4E;
  localparam logic [7:0]  CMD_DISABLE    = 8'hB1;
  localparam logic [7:0]  CMD_TRAPCOMMIT = 8'hD2;

  // status register fields
  localparam int          ST_RUNNING     = 0;
  localparam int          ST_ENABLE      = 1;
  localparam int          ST_OUTSEL      = 2;
  localparam int          ST_TRAPACT     = 3;
  localparam int          ST_RAMCOMMIT   = 4;
  localparam int          ST_RAMPEND     = 5;
  localparam int          ST_CNT_LO      = 6;
  localparam int          ST_RSTACTIVE   = 8;

  // fetch address areas
  localparam logic [15:0] SFR_LO         = 16'h0000;
  localparam logic [15:0] SFR_HI         = 16'h003F;
  localparam logic [15:0] RAM_LO         = 16'h0040;
  localparam logic [15:0] RAM_HI         = 16'h083F;
  localparam logic [15:0] DBR_LO         = 16'h0F80;
  localparam logic [15:0] DBR_HI         = 16'h0FFF;

  // reset pulse timing, mclk serves as the high-frequency clock
  localparam longint      FC_HZ          = 40000000;
  localparam longint      MCLK_HZ        = 40000000;
  localparam longint      RST_TIME_FC    = 24;
  localparam int          RST_CYCLES_RAW = int'((RST_TIME_FC * MCLK_HZ) / FC_HZ);
  localparam int          RST_CYCLES     = (RST_CYCLES_RAW < 1) ? 1 : RST_CYCLES_RAW;
  localparam logic [4:0]  RST_LAST       = 5'(RST_CYCLES - 1);

  // divider tap spacing between adjacent detect-time codes
  localparam int          TAP_STEP       = 2;

  typedef enum logic [0:0] {
    RS_IDLE  = 1'b0,
    RS_PULSE = 1'b1
  } wdat_rst_state_t;

endpackage : wdat_pkg

// ### core/wdat_watchdog_trap.sv
// The APB register port was decided locally.
`timescale 1ns/1ps
module wdat_watchdog_trap #(
  parameter int DIV_TOP = 22
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [9:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        fetchValid,
  input  wire logic [15:0] fetchAddr,
  input  wire logic        lowPowerHold,
  input  wire logic        lowSpeedMode,
  output logic             wdInterruptReq,
  output logic             fetchTrapInterruptReq,
  output logic             sysResetReq,
  output logic             hfOscRestartReq
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic inArea(input logic [15:0] a, input logic [15:0] lo,
                                  input logic [15:0] hi);
    inArea = (a >= lo) && (a <= hi);
  endfunction : inArea

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: one wait state, so pready comes from a flop
  logic [31:0] prdata_q, prdata_d;
  logic        pready_q, pready_d;
  logic        pslverr_q, pslverr_d;
  logic        acc, ctrlWr, cmdWr;
  logic [7:0]  wByte;
  logic [31:0] statusWord;

  always_comb begin
    acc       = psel && penable && pready_q;
    wByte     = pwdata[7:0];
    ctrlWr    = acc && pwrite && (paddr == wdat_pkg::CTRL_ADDR);
    cmdWr     = acc && pwrite && (paddr == wdat_pkg::CMD_ADDR);
    pready_d  = psel && penable && !pready_q;
    prdata_d  = 32'h0000_0000;
    pslverr_d = 1'b0;
    if (pready_d) begin
      unique case (paddr)
        wdat_pkg::CTRL_ADDR, wdat_pkg::CMD_ADDR: prdata_d = 32'h0000_0000;
        wdat_pkg::STAT_ADDR:                     prdata_d = statusWord;
        default:                                 pslverr_d = 1'b1;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  ////////////////////////////////////////////////////////////////////////////
  // watchdog: free divider, two-bit binary counter on the selected tap
  logic [DIV_TOP:0] div_q, div_d;
  logic [1:0]       cnt_q, cnt_d;
  logic [1:0]       dtSel_q, dtSel_d;
  logic             tapPrev_q, tapPrev_d;
  logic             enBit_q, enBit_d;
  logic             running_q, running_d;
  logic             outSel_q, outSel_d;
  logic             trapAct_q, trapAct_d;
  logic             ramPend_q, ramPend_d;
  logic             ramCommit_q, ramCommit_d;
  logic             tap, tick, ovf;

  always_comb begin
    tap         = div_q[DIV_TOP - wdat_pkg::TAP_STEP * int'(dtSel_q)];  // RULE_22
    tick        = tap && !tapPrev_q && running_q && !lowPowerHold;
    ovf         = tick && (cnt_q == 2'h3);
    div_d       = lowPowerHold ? div_q : div_q + 1'b1;                   // RULE_15
    tapPrev_d   = tap;
    enBit_d     = enBit_q;
    running_d   = running_q;
    outSel_d    = outSel_q;
    dtSel_d     = dtSel_q;
    trapAct_d   = trapAct_q;
    ramPend_d   = ramPend_q;
    ramCommit_d = ramCommit_q;
    cnt_d       = tick ? cnt_q + 2'h1 : cnt_q;
    if (ctrlWr) begin
      enBit_d   = wByte[wdat_pkg::CTL_ENABLE];
      running_d = running_q || wByte[wdat_pkg::CTL_ENABLE];
      dtSel_d   = wByte[wdat_pkg::CTL_DT_HI:wdat_pkg::CTL_DT_LO];
      outSel_d  = outSel_q && wByte[wdat_pkg::CTL_OUTSEL];             // RULE_11
      trapAct_d = wByte[wdat_pkg::CTL_TRAPACT];
      ramPend_d = wByte[wdat_pkg::CTL_RAMTRAP];
    end
    if (cmdWr) begin
      unique case (wByte)                                              // RULE_03
        wdat_pkg::CMD_CLEAR:      cnt_d = 2'h0;                        // RULE_06
        wdat_pkg::CMD_DISABLE:    if (!enBit_q) running_d = 1'b0;      // RULE_04
        wdat_pkg::CMD_TRAPCOMMIT: ramCommit_d = ramPend_q;             // RULE_16
        default:                  cnt_d = cnt_d;
      endcase
    end
    if (!running_d) begin
      cnt_d = 2'h0;                                                    // RULE_05
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      div_q       <= '0;
      cnt_q       <= 2'h0;
      tapPrev_q   <= 1'b0;
      enBit_q     <= wdat_pkg::CTRL_RESET[wdat_pkg::CTL_ENABLE];       // RULE_01
      running_q   <= 1'b1;                                             // RULE_01
      outSel_q    <= wdat_pkg::CTRL_RESET[wdat_pkg::CTL_OUTSEL];
      dtSel_q     <= wdat_pkg::CTRL_RESET[wdat_pkg::CTL_DT_HI:wdat_pkg::CTL_DT_LO];
      trapAct_q   <= wdat_pkg::CTRL_RESET[wdat_pkg::CTL_TRAPACT];
      ramPend_q   <= wdat_pkg::CTRL_RESET[wdat_pkg::CTL_RAMTRAP];
      ramCommit_q <= wdat_pkg::CTRL_RESET[wdat_pkg::CTL_RAMTRAP];
    end else begin
      div_q       <= div_d;
      cnt_q       <= cnt_d;
      tapPrev_q   <= tapPrev_d;
      enBit_q     <= enBit_d;
      running_q   <= running_d;
      outSel_q    <= outSel_d;
      dtSel_q     <= dtSel_d;
      trapAct_q   <= trapAct_d;
      ramPend_q   <= ramPend_d;
      ramCommit_q <= ramCommit_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // events: non-maskable pulses and the timed reset request
  wdat_pkg::wdat_rst_state_t rs_q, rs_d;
  logic [4:0] rstCnt_q, rstCnt_d;
  logic       wdIrq_q, wdIrq_d;
  logic       trapIrq_q, trapIrq_d;
  logic       hfRestart_q, hfRestart_d;
  logic       trapHit, wantReset;

  always_comb begin
    // register areas trap unconditionally, ram only once committed
    trapHit     = fetchValid && (inArea(fetchAddr, wdat_pkg::SFR_LO, wdat_pkg::SFR_HI) ||
                  inArea(fetchAddr, wdat_pkg::DBR_LO, wdat_pkg::DBR_HI) ||       // RULE_17
                  (ramCommit_q && inArea(fetchAddr, wdat_pkg::RAM_LO, wdat_pkg::RAM_HI)));
    // no interrupt flag gating: these requests reach the core unless a reset pulse is running
    wdIrq_d     = ovf && !outSel_q && (rs_q == wdat_pkg::RS_IDLE);      // RULE_07 RULE_08 RULE_09
    trapIrq_d   = trapHit && !trapAct_q && (rs_q == wdat_pkg::RS_IDLE); // RULE_18 RULE_20 RULE_21
    wantReset   = (ovf && outSel_q) || (trapHit && trapAct_q);          // RULE_12 RULE_19
    rs_d        = rs_q;
    rstCnt_d    = rstCnt_q;
    hfRestart_d = hfRestart_q;
    unique case (rs_q)
      wdat_pkg::RS_IDLE: begin
        if (wantReset) begin
          rs_d        = wdat_pkg::RS_PULSE;
          rstCnt_d    = 5'h00;
          hfRestart_d = lowSpeedMode;                                   // RULE_14
        end
      end
      wdat_pkg::RS_PULSE: begin
        // further events are dropped, the core is being reset anyway
        if (rstCnt_q == wdat_pkg::RST_LAST) begin                      // RULE_13
          rs_d        = wdat_pkg::RS_IDLE;
          hfRestart_d = 1'b0;
        end else begin
          rstCnt_d = rstCnt_q + 5'h01;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rs_q        <= wdat_pkg::RS_IDLE;
      rstCnt_q    <= 5'h00;
      wdIrq_q     <= 1'b0;
      trapIrq_q   <= 1'b0;
      hfRestart_q <= 1'b0;
    end else begin
      rs_q        <= rs_d;
      rstCnt_q    <= rstCnt_d;
      wdIrq_q     <= wdIrq_d;
      trapIrq_q   <= trapIrq_d;
      hfRestart_q <= hfRestart_d;
    end
  end

  assign wdInterruptReq        = wdIrq_q;
  assign fetchTrapInterruptReq = trapIrq_q;
  assign sysResetReq           = (rs_q == wdat_pkg::RS_PULSE);
  assign hfOscRestartReq       = hfRestart_q;

  always_comb begin
    statusWord                                    = 32'h0000_0000;
    statusWord[wdat_pkg::ST_RUNNING]              = running_q;
    statusWord[wdat_pkg::ST_ENABLE]               = enBit_q;
    statusWord[wdat_pkg::ST_OUTSEL]               = outSel_q;
    statusWord[wdat_pkg::ST_TRAPACT]              = trapAct_q;
    statusWord[wdat_pkg::ST_RAMCOMMIT]            = ramCommit_q;
    statusWord[wdat_pkg::ST_RAMPEND]              = ramPend_q;
    statusWord[wdat_pkg::ST_CNT_LO +: 2]          = cnt_q;
    statusWord[wdat_pkg::ST_RSTACTIVE]            = (rs_q == wdat_pkg::RS_PULSE);
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  property p_en_after_reset;
    $fell(rst) |-> running_q && enBit_q;
  endproperty
  a_en_after_reset: assert property (p_en_after_reset) else $error("not enabled after reset"); // RULE_01

  property p_bad_code;
    cmdWr && wByte != wdat_pkg::CMD_CLEAR && wByte != wdat_pkg::CMD_DISABLE &&
      wByte != wdat_pkg::CMD_TRAPCOMMIT && !ctrlWr |=> $stable(ramCommit_q) && $stable(running_q);
  endproperty
  a_bad_code: assert property (p_bad_code) else $error("invalid code had an effect"); // RULE_03

  property p_disable_guard;
    cmdWr && wByte == wdat_pkg::CMD_DISABLE && enBit_q && running_q |=> running_q;
  endproperty
  a_disable_guard: assert property (p_disable_guard) else $error("disable code acted"); // RULE_04

  property p_disabled_clear;
    !running_q |-> cnt_q == 2'h0;
  endproperty
  a_disabled_clear: assert property (p_disabled_clear) else $error("counter not held"); // RULE_05

  property p_clear_code;
    cmdWr && wByte == wdat_pkg::CMD_CLEAR |=>
      cnt_q == 2'h0 && (div_q == $past(div_q) + 1'b1 || $past(lowPowerHold));
  endproperty
  a_clear_code: assert property (p_clear_code) else $error("clear code failed"); // RULE_06

  property p_wd_irq;
    ovf && !outSel_q && !sysResetReq |=> wdInterruptReq && !sysResetReq;
  endproperty
  a_wd_irq: assert property (p_wd_irq) else $error("watchdog interrupt missing"); // RULE_07

  property p_outsel_sticky;
    !outSel_q |=> !outSel_q;
  endproperty
  a_outsel_sticky: assert property (p_outsel_sticky) else $error("output select set again"); // RULE_11

  property p_wd_reset;
    ovf && outSel_q && !sysResetReq |=> sysResetReq && !wdInterruptReq;
  endproperty
  a_wd_reset: assert property (p_wd_reset) else $error("watchdog reset missing"); // RULE_12

  property p_reset_len;
    $rose(sysResetReq) |-> ##23 sysResetReq ##1 !sysResetReq;
  endproperty
  a_reset_len: assert property (p_reset_len) else $error("reset pulse length wrong"); // RULE_13

  property p_hf_restart;
    $rose(sysResetReq) && $past(lowSpeedMode) |-> hfOscRestartReq;
  endproperty
  a_hf_restart: assert property (p_hf_restart) else $error("oscillator not restarted"); // RULE_14

  property p_hold;
    lowPowerHold |=> $stable(div_q) && $stable(cnt_q);
  endproperty
  a_hold: assert property (p_hold) else $error("count moved while held"); // RULE_15

  property p_commit_only;
    ctrlWr |=> $stable(ramCommit_q);
  endproperty
  a_commit_only: assert property (p_commit_only) else $error("ram trap changed without code"); // RULE_16

  property p_trap_irq;
    fetchValid && inArea(fetchAddr, wdat_pkg::SFR_LO, wdat_pkg::SFR_HI) && !trapAct_q &&
      !sysResetReq |=> fetchTrapInterruptReq;
  endproperty
  a_trap_irq: assert property (p_trap_irq) else $error("trap interrupt missing"); // RULE_17

  property p_trap_reset;
    trapHit && trapAct_q && !sysResetReq |=> sysResetReq && !fetchTrapInterruptReq;
  endproperty
  a_trap_reset: assert property (p_trap_reset) else $error("trap reset missing"); // RULE_19

  c_wd_irq:     cover property (wdInterruptReq);
  c_wd_reset:   cover property ($rose(sysResetReq) && !outSel_q == 1'b0);
  c_trap_irq:   cover property (fetchTrapInterruptReq);
  c_disable:    cover property (cmdWr && wByte == wdat_pkg::CMD_DISABLE && !enBit_q);

endmodule : wdat_watchdog_trap

// ### sim/wdat_cpu_model.sv
`timescale 1ns/1ps
module wdat_cpu_model (
  input  wire logic        mclk,
  input  wire logic        wdInterruptReq,
  input  wire logic        fetchTrapInterruptReq,
  input  wire logic        sysResetReq,
  output logic             fetchValid,
  output logic [15:0]      fetchAddr
);
  logic globalIrqEnableFlag;
  logic stackReady;
  int   nestDepth;
  int   nWdIrq;
  int   nTrapIrq;
  int   nMaskedTaken;
  int   nNoStack;

  initial begin
    fetchValid          = 1'b0;
    fetchAddr           = 16'hFFFF;
    globalIrqEnableFlag = 1'b1;
    stackReady          = 1'b0;
    nestDepth           = 0;
    nWdIrq              = 0;
    nTrapIrq            = 0;
    nMaskedTaken        = 0;
    nNoStack            = 0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // nonmaskable requests are taken whatever the global flag, and nest deeper
  always @(posedge mclk) begin
    if (wdInterruptReq === 1'b1) begin
      nWdIrq++;
      nestDepth++;
    end
    if (fetchTrapInterruptReq === 1'b1) begin
      nTrapIrq++;
      nestDepth++;
    end
    // taken even with the global flag low
    if ((wdInterruptReq === 1'b1 || fetchTrapInterruptReq === 1'b1) && !globalIrqEnableFlag) begin
      nMaskedTaken++;
    end
    // an interrupt before the stack is set would corrupt memory
    if ((wdInterruptReq === 1'b1 || fetchTrapInterruptReq === 1'b1) && !stackReady) begin
      nNoStack++;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // one-cycle fetch; the bus shows the inverted address once released
  task automatic fetch(input logic [15:0] a, output logic t, output logic r);
    @(posedge mclk);
    fetchValid <= 1'b1;
    fetchAddr  <= a;
    @(posedge mclk);
    fetchValid <= 1'b0;
    fetchAddr  <= ~a;
    #1;
    t = fetchTrapInterruptReq;
    r = sysResetReq;
  endtask : fetch
endmodule : wdat_cpu_model

// ### sim/wdat_watchdog_trap_tb_top.sv
`timescale 1ns/1ps
module wdat_watchdog_trap_tb_top;
  localparam int DIV = 6;
  logic        mclk, rst, psel, penable, pwrite, fetchValid, lowPowerHold, lowSpeedMode;
  logic [9:0]  paddr;
  logic [31:0] pwdata, prdata, seed, rd, d;
  logic [15:0] fetchAddr, a;
  logic        pready, pslverr, wdInterruptReq, fetchTrapInterruptReq;
  logic        sysResetReq, hfOscRestartReq, t, r, err, ram, lastHf;
  int          n_errors, n_checks, cyc, rstRun, lastLen, n, t0, p, n0;
  logic [15:0] tbl [8] = '{16'h0000, 16'h003F, 16'h0040, 16'h083F,
                           16'h0840, 16'h0F7F, 16'h0F80, 16'h0FFF};

  wdat_watchdog_trap #(.DIV_TOP(DIV)) u_wdat_watchdog_trap (
    .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fetchValid(fetchValid), .fetchAddr(fetchAddr), .lowPowerHold(lowPowerHold),
    .lowSpeedMode(lowSpeedMode), .wdInterruptReq(wdInterruptReq),
    .fetchTrapInterruptReq(fetchTrapInterruptReq), .sysResetReq(sysResetReq),
    .hfOscRestartReq(hfOscRestartReq));

  wdat_cpu_model u_wdat_cpu_model (
    .mclk(mclk), .wdInterruptReq(wdInterruptReq), .fetchTrapInterruptReq(fetchTrapInterruptReq),
    .sysResetReq(sysResetReq), .fetchValid(fetchValid), .fetchAddr(fetchAddr));

  initial mclk = 1'b0;
  always #12.5 mclk = ~mclk;

  ////////////////////////////////////////////////////////////////////////////////
  // cycle count, hang limit and reset pulse length measured at every rising edge
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      complete_run();
    end
    if (sysResetReq === 1'b1) begin
      if (rstRun == 0) lastHf = hfOscRestartReq;
      rstRun++;
    end else if (rstRun != 0) begin
      lastLen = rstRun;
      rstRun  = 0;
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic logic exp_trap(input logic [15:0] x, input logic rm);
    return (x <= wdat_pkg::SFR_HI) || (x >= wdat_pkg::DBR_LO && x <= wdat_pkg::DBR_HI) ||
           (rm && x >= wdat_pkg::RAM_LO && x <= wdat_pkg::RAM_HI);
  endfunction : exp_trap

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [9:0] ad, input logic [31:0] wd);
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= ad;
    pwdata  <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // edges until the chosen output is seen, mx if never
  task automatic wait_evt(input logic s, input int mx, output int k);
    k = 0;
    while (k < mx && (s ? sysResetReq : wdInterruptReq) !== 1'b1) begin
      @(posedge mclk);
      k++;
    end
  endtask : wait_evt

  task automatic do_reset();
    @(posedge mclk);
    rst <= 1'b1;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
  endtask : do_reset

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {psel, penable, pwrite, lowPowerHold, lowSpeedMode} = 5'h00;
    paddr = 10'h000;
    pwdata = 32'h0;
    seed = 32'd49355;
    {n_errors, n_checks, cyc, rstRun, lastLen} = '0;
    rst = 1'b1;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    apb(1'b0, wdat_pkg::STAT_ADDR, 32'h0);
    chk("status after reset", 32'h3F, rd & 32'h1FF);
    apb(1'b0, wdat_pkg::CTRL_ADDR, 32'h0);
    chk("control read", 32'h0, rd);
    apb(1'b0, 10'h010, 32'h0);
    chk("unmapped error", 32'h1, 32'(err));
    lowSpeedMode <= 1'b1;
    wait_evt(1'b1, 600, n);
    chk("overflow reset", 32'h1, 32'(n < 600));
    repeat (30) @(posedge mclk);
    chk("reset length", 32'd24, 32'(lastLen));
    chk("osc restart", 32'h1, 32'(lastHf));
    $display("test reset mode done");
    do_reset();
    lowSpeedMode <= 1'b0;
    // clear lands just before a tap edge, so overflow comes near three quarters
    repeat (184) @(posedge mclk);
    apb(1'b1, wdat_pkg::CMD_ADDR, 32'h4E);
    t0 = cyc;
    repeat (6) begin
      repeat (30) @(posedge mclk);
      d = rnd() & 32'hFF;
      if (d == 32'h4E || d == 32'hB1 || d == 32'hD2) d ^= 32'h1;
      apb(1'b1, wdat_pkg::CMD_ADDR, d);
    end
    wait_evt(1'b1, 600, n);
    n = cyc - t0;
    p = 1 << (DIV + 1);
    chk("clear timing", 32'h1, 32'(n >= 3 * p && n <= 3 * p + p / 8));
    do_reset();
    apb(1'b1, wdat_pkg::CMD_ADDR, 32'hB1);
    wait_evt(1'b1, 600, n);
    chk("disable ignored", 32'h1, 32'(n < 600));
    chk("no osc restart", 32'h0, 32'(hfOscRestartReq));
    do_reset();
    u_wdat_cpu_model.globalIrqEnableFlag = 1'b0;
    apb(1'b1, wdat_pkg::CMD_ADDR, 32'h4E);
    apb(1'b1, wdat_pkg::CTRL_ADDR, 32'h31);
    apb(1'b1, wdat_pkg::CMD_ADDR, 32'hB1);
    apb(1'b0, wdat_pkg::STAT_ADDR, 32'h0);
    chk("stopped counter", 32'h0, rd & 32'hC1);
    wait_evt(1'b1, 700, n);
    chk("no overflow", 32'd700, 32'(n));
    $display("test disable done");
    do_reset();
    u_wdat_cpu_model.stackReady = 1'b1;
    n0 = u_wdat_cpu_model.nWdIrq;
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, wdat_pkg::CTRL_ADDR, 32'h38 | 32'(c << 1));
      apb(1'b1, wdat_pkg::CMD_ADDR, 32'h4E);
      wait_evt(1'b0, 600, n);
      p = 1 << (DIV + 1 - 2 * c);
      chk("detect time", 32'h1, 32'(n >= 3 * p && n <= 4 * p + 3));
    end
    chk("irq taken", 32'h1, 32'(u_wdat_cpu_model.nWdIrq > n0));
    apb(1'b1, wdat_pkg::CTRL_ADDR, 32'h3F);
    wait_evt(1'b0, 20, n);
    chk("select sticky", 32'h1, 32'(n < 20));
    apb(1'b0, wdat_pkg::STAT_ADDR, 32'h0);
    chk("select bit", 32'h0, (rd >> 2) & 32'h1);
    @(posedge mclk);
    lowPowerHold <= 1'b1;
    repeat (3) @(posedge mclk);
    wait_evt(1'b0, 200, n);
    chk("held count", 32'd200, 32'(n));
    lowPowerHold <= 1'b0;
    wait_evt(1'b0, 14, n);
    chk("resumed count", 32'h1, 32'(n < 14));
    $display("test interrupt mode done");
    do_reset();
    lowSpeedMode <= 1'b1;
    u_wdat_cpu_model.fetch(16'h0020, t, r);
    chk("trap reset", 32'h1, 32'(r));
    repeat (30) @(posedge mclk);
    chk("trap reset length", 32'd24, 32'(lastLen));
    chk("trap osc restart", 32'h1, 32'(lastHf));
    do_reset();
    lowSpeedMode <= 1'b0;
    apb(1'b1, wdat_pkg::CTRL_ADDR, 32'h28);
    ram = 1'b1;
    for (int i = 0; i < 48; i++) begin
      if (i == 24) apb(1'b1, wdat_pkg::CTRL_ADDR, 32'h08);
      if (i == 32) apb(1'b1, wdat_pkg::CMD_ADDR, 32'hD2);
      if (i == 32) ram = 1'b0;
      a = (i % 24 < 8) ? tbl[i % 8] : 16'(rnd() & 32'h0FFF);
      u_wdat_cpu_model.fetch(a, t, r);
      chk("trap interrupt", 32'(exp_trap(a, ram)), 32'(t));
    end
    chk("taken while masked", 32'h1, 32'(u_wdat_cpu_model.nMaskedTaken > 0));
    chk("irq without stack", 32'h0, 32'(u_wdat_cpu_model.nNoStack));
    $display("test address trap done");
    complete_run();
  end
endmodule : wdat_watchdog_trap_tb_top
